//--- pkg/dio_latch_irq_params.svh
// Register map, field positions and reset values of the input latch and interrupt block.
`ifndef DIO_LATCH_IRQ_PARAMS_SVH
`define DIO_LATCH_IRQ_PARAMS_SVH

`define ADDR_W          8
`define OFS_G1_SETUP    8'h00
`define OFS_G2_SETUP    8'h04
`define OFS_SHARED      8'h08
`define OFS_STATUS      8'h0c
`define OFS_MASK        8'h10
`define OFS_G1_PORT     8'h14
`define OFS_G2_PORT     8'h18
`define OFS_G1_TC_ACK   8'h1c
`define OFS_G2_TC_ACK   8'h20
`define OFS_T3_ACK      8'h24

`define SETUP_W         7
`define SETUP_RST       7'h00
`define B_RDY_EN        0
`define B_PULSE         1
`define B_EDGE          2
`define B_INVERT        3
`define B_DOUBLE_BUFFER_SELECT        4
`define B_HS_EN         5
`define B_INPUT         6

`define SHARED_W        3
`define SHARED_RST      3'h0
`define B_TC1_EN        0
`define B_TC2_EN        1
`define B_T3_EN         2

`define ST_W            5
`define ST_RST          5'h00
`define ST_RDY1         0
`define ST_RDY2         1
`define ST_TC1          2
`define ST_TC2          3
`define ST_T3           4
`define ST_LINE1_MASK   5'h05
`define ST_LINE2_MASK   5'h1a

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define SYNC_STAGES     3

`endif

//--- pkg/dio_latch_irq_pkg.sv
// Types shared by the input latch and interrupt block.
package dio_latch_irq_pkg;

    typedef enum logic [1:0] {
        MODE_LEVEL    = 2'b00,
        MODE_LEADING  = 2'b01,
        MODE_TRAILING = 2'b11
    } mode_type;

endpackage : dio_latch_irq_pkg

//--- verilog/dio_latch_irq.sv
// Input data latch and five-source interrupt logic behind an AXI4-Lite register slave.
//
// Summary of operation
// RULE1: Plain input port reads return live lines.
// RULE2: Double-buffered handshake input captures on request.
// RULE3: Level mode: capture at leading edge, hold.
// RULE4: Pulse mode: active edge captures, held until read.
// RULE5: Five interrupt sources exist.
// RULE6: Each source has enable and status bits.
// RULE7: Status register shows active interrupt requests.
// RULE8: Port read or write clears data ready.
// RULE9: Final count ack write clears that flag.
// RULE10: Timer ack write clears timer flag.
// RULE11: Timer interrupt uses the group 2 line.
// RULE12: Timer rising edge sets flag, raises request.
// RULE13: Ready enables live in group setup registers.
// RULE14: Final count and timer enables in shared.
// RULE15: Final count input sets group flag.
// RULE16: Pulse and edge bits select handshake mode.
// RULE17: Invert bit makes request active low.
// RULE18: Line 1 group 1, line 2 group 2 plus timer.
// RULE19: Ack writes ignore data, spare other flags.
`include "dio_latch_irq_params.svh"

module dio_latch_irq #(
    parameter int GW = 16
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst_n,
    // AXI4-Lite write address and data.
    input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Connector pins and event inputs, asynchronous.
    input  wire logic [GW-1:0]       group1_lines,
    input  wire logic [GW-1:0]       group2_lines,
    input  wire logic                group1_request,
    input  wire logic                group2_request,
    input  wire logic                group1_dma_final_count,
    input  wire logic                group2_dma_final_count,
    input  wire logic                timer3_out,
    // Interrupt lines.
    output logic                     group1_irq,
    output logic                     group2_irq,
    output logic                     irq
);

    localparam int PW = 2 * GW + 5;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a bit moves on only once the second and third stages agree.

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] sync1_r;
    logic [PW-1:0] sync2_r;
    logic [PW-1:0] sync3_r;
    logic [PW-1:0] flt_r;

    assign pin_raw = {timer3_out, group2_dma_final_count, group1_dma_final_count,
                      group2_request, group1_request, group2_lines, group1_lines};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            flt_r   <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            flt_r   <= (flt_r & ~(sync2_r ~^ sync3_r)) | (sync3_r & (sync2_r ~^ sync3_r));
        end
    end

    logic [GW-1:0] live [2];
    logic [1:0]    req_f;
    logic [1:0]    tc_f;
    logic          t3_f;

    assign live[0] = flt_r[GW-1:0];
    assign live[1] = flt_r[2*GW-1:GW];
    assign req_f   = flt_r[2*GW+1:2*GW];
    assign tc_f    = flt_r[2*GW+3:2*GW+2];
    assign t3_f    = flt_r[2*GW+4];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    logic [`SETUP_W-1:0]  setup_r [2];
    logic [`SHARED_W-1:0] shared_r;
    logic [`ST_W-1:0]     status_r;
    logic [`ST_W-1:0]     mask_r;
    logic [GW-1:0]        buf_r [2];
    logic [`ADDR_W-1:0]   wa_r;
    logic [31:0]          wd_r;
    logic                 aw_got_r;
    logic                 w_got_r;
    logic                 do_wr;
    logic                 do_rd;

    function automatic logic mapped(input logic [`ADDR_W-1:0] a);
        case (a)
            `OFS_G1_SETUP, `OFS_G2_SETUP, `OFS_SHARED, `OFS_STATUS, `OFS_MASK,
            `OFS_G1_PORT, `OFS_G2_PORT, `OFS_G1_TC_ACK, `OFS_G2_TC_ACK,
            `OFS_T3_ACK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            wa_r          <= '0;
            wd_r          <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wa_r          <= s_axi_awaddr;
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_r         <= s_axi_wdata;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wa_r) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Byte enables are not honoured; every register is narrower than one lane group.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_r[0] <= `SETUP_RST;
            setup_r[1] <= `SETUP_RST;
            shared_r   <= `SHARED_RST;
            mask_r     <= `ST_RST;
        end else if (do_wr) begin
            case (wa_r)
                `OFS_G1_SETUP: setup_r[0] <= wd_r[`SETUP_W-1:0]; // RULE13
                `OFS_G2_SETUP: setup_r[1] <= wd_r[`SETUP_W-1:0]; // RULE13
                `OFS_SHARED:   shared_r   <= wd_r[`SHARED_W-1:0]; // RULE14
                `OFS_MASK:     mask_r     <= wd_r[`ST_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (do_rd) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_G1_SETUP: s_axi_rdata <= 32'(setup_r[0]);
                `OFS_G2_SETUP: s_axi_rdata <= 32'(setup_r[1]);
                `OFS_SHARED:   s_axi_rdata <= 32'(shared_r);
                `OFS_STATUS:   s_axi_rdata <= 32'(status_r); // RULE7
                `OFS_MASK:     s_axi_rdata <= 32'(mask_r);
                `OFS_G1_PORT:  s_axi_rdata <= 32'(port_view(setup_r[0], buf_r[0], live[0])); // RULE1
                `OFS_G2_PORT:  s_axi_rdata <= 32'(port_view(setup_r[1], buf_r[1], live[1])); // RULE1
                default:       s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Handshake request decode and input buffers.

    function automatic dio_latch_irq_pkg::mode_type dec_mode(input logic [`SETUP_W-1:0] s);
        case ({s[`B_EDGE], s[`B_PULSE]})
            2'b01:   dec_mode = dio_latch_irq_pkg::MODE_LEADING;
            2'b11:   dec_mode = dio_latch_irq_pkg::MODE_TRAILING;
            default: dec_mode = dio_latch_irq_pkg::MODE_LEVEL;
        endcase
    endfunction : dec_mode

    function automatic logic [GW-1:0] port_view(input logic [`SETUP_W-1:0] s,
                                                input logic [GW-1:0] b,
                                                input logic [GW-1:0] l);
        port_view = (s[`B_DOUBLE_BUFFER_SELECT] && s[`B_INPUT]) ? b : l;
    endfunction : port_view

    logic [1:0] act;
    logic [1:0] act_q_r;
    logic [1:0] lead;
    logic [1:0] trail;
    logic [1:0] fire;
    logic [1:0] capture_on;
    logic [1:0] held_r;
    logic [1:0] rd_port;
    logic [1:0] wr_port;
    dio_latch_irq_pkg::mode_type mode [2];

    for (genvar g = 0; g < 2; g++) begin : g_req
        assign mode[g]       = dec_mode(setup_r[g]); // RULE16
        assign act[g]        = req_f[g] ^ setup_r[g][`B_INVERT]; // RULE17
        assign lead[g]       = act[g] && !act_q_r[g];
        assign trail[g]      = !act[g] && act_q_r[g];
        assign fire[g]       = setup_r[g][`B_HS_EN] &&
                               ((mode[g] == dio_latch_irq_pkg::MODE_TRAILING) ? trail[g] : lead[g]);
        assign capture_on[g] = setup_r[g][`B_INPUT] && setup_r[g][`B_DOUBLE_BUFFER_SELECT] &&
                               setup_r[g][`B_HS_EN];
    end

    assign rd_port[0] = do_rd && (s_axi_araddr == `OFS_G1_PORT);
    assign rd_port[1] = do_rd && (s_axi_araddr == `OFS_G2_PORT);
    assign wr_port[0] = do_wr && (wa_r == `OFS_G1_PORT);
    assign wr_port[1] = do_wr && (wa_r == `OFS_G2_PORT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q_r <= '0;
        end else begin
            act_q_r <= act;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
            held_r   <= '0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (!capture_on[g]) begin
                    held_r[g] <= 1'b0;
                end else if (mode[g] == dio_latch_irq_pkg::MODE_LEVEL) begin
                    held_r[g] <= 1'b0;
                    if (lead[g] || !act[g]) begin
                        buf_r[g] <= live[g]; // RULE2 RULE3
                    end
                end else if (fire[g] && !held_r[g]) begin
                    buf_r[g]  <= live[g]; // RULE2 RULE4
                    held_r[g] <= 1'b1;
                end else if (rd_port[g]) begin
                    held_r[g] <= 1'b0; // RULE4
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enables and lines. A new event wins over a clear in the same cycle.

    logic             t3_q_r;
    logic [1:0]       tc_q_r;
    logic [`ST_W-1:0] ev;
    logic [`ST_W-1:0] clr;
    logic [`ST_W-1:0] en;
    logic [`ST_W-1:0] pend;

    assign ev = {t3_f && !t3_q_r, tc_f & ~tc_q_r, fire}; // RULE5 RULE12 RULE15
    assign en = {shared_r[`B_T3_EN], shared_r[`B_TC2_EN], shared_r[`B_TC1_EN],
                 setup_r[1][`B_RDY_EN], setup_r[0][`B_RDY_EN]}; // RULE6 RULE13 RULE14
    assign clr[`ST_RDY1] = rd_port[0] || wr_port[0]; // RULE8
    assign clr[`ST_RDY2] = rd_port[1] || wr_port[1]; // RULE8
    assign clr[`ST_TC1]  = do_wr && ((wa_r == `OFS_G1_TC_ACK) ||
                           (wa_r == `OFS_STATUS && wd_r[`ST_TC1])); // RULE9 RULE19
    assign clr[`ST_TC2]  = do_wr && ((wa_r == `OFS_G2_TC_ACK) ||
                           (wa_r == `OFS_STATUS && wd_r[`ST_TC2])); // RULE9 RULE19
    assign clr[`ST_T3]   = do_wr && ((wa_r == `OFS_T3_ACK) ||
                           (wa_r == `OFS_STATUS && wd_r[`ST_T3])); // RULE10 RULE19
    assign pend = status_r & en; // RULE6

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t3_q_r   <= 1'b0;
            tc_q_r   <= '0;
            status_r <= `ST_RST;
        end else begin
            t3_q_r   <= t3_f;
            tc_q_r   <= tc_f;
            status_r <= (status_r & ~clr) | ev; // RULE7 RULE8 RULE9 RULE10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            group1_irq <= 1'b0;
            group2_irq <= 1'b0;
            irq        <= 1'b0;
        end else begin
            group1_irq <= |(pend & `ST_LINE1_MASK); // RULE18
            group2_irq <= |(pend & `ST_LINE2_MASK); // RULE11 RULE18
            irq        <= |(status_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack_tc1;
        do_wr && wa_r == `OFS_G1_TC_ACK && !ev[`ST_TC1];
    endsequence

    sequence s_pulse_capture;
        capture_on[0] && mode[0] != dio_latch_irq_pkg::MODE_LEVEL && fire[0] && !held_r[0];
    endsequence

    AST_RDY_SETS: assert property (fire[1] |=> status_r[`ST_RDY2]) // RULE6
        else $error("Group 2 ready not set by request.");
    AST_RDY_CLEARS: assert property (rd_port[0] && !fire[0] |=> !status_r[`ST_RDY1]) // RULE8
        else $error("Group 1 ready not cleared by port read.");
    AST_TC_ACK: assert property (s_ack_tc1 |=> !status_r[`ST_TC1]) // RULE9
        else $error("Final count flag not cleared by ack.");
    AST_ACK_SPARES: assert property (s_ack_tc1 ##0 status_r[`ST_T3] |=> status_r[`ST_T3]) // RULE19
        else $error("Ack disturbed another flag.");
    AST_T3_IRQ: assert property (ev[`ST_T3] && en[`ST_T3] ##1 en[`ST_T3] |=> group2_irq) // RULE11
        else $error("Timer event did not reach group 2 line.");
    AST_T3_NOT_LINE1: assert property ((pend & `ST_LINE1_MASK) == '0 |=> !group1_irq) // RULE18
        else $error("Group 1 line raised without group 1 source.");
    AST_TC_SET: assert property (!tc_q_r[0] && tc_f[0] |=> status_r[`ST_TC1]) // RULE15
        else $error("Final count edge not recorded.");
    AST_LIVE_READ: assert property (rd_port[0] && !setup_r[0][`B_DOUBLE_BUFFER_SELECT]
                                    |=> s_axi_rdata == 32'($past(live[0]))) // RULE1
        else $error("Plain port read did not return live lines.");
    AST_PULSE_HOLD: assert property (s_pulse_capture ##1 !rd_port[0] && capture_on[0]
                                     |=> $stable(buf_r[0])) // RULE4
        else $error("Pulse capture not held until read.");
    AST_LEVEL_HOLD: assert property (capture_on[0] && mode[0] == dio_latch_irq_pkg::MODE_LEVEL
                                     && act[0] && !lead[0] |=> $stable(buf_r[0])) // RULE3
        else $error("Level capture changed while request active.");
    AST_WRITE_RESP: assert property (do_wr |=> s_axi_bvalid ##0 !s_axi_awready)
        else $error("Write not answered.");

endmodule : dio_latch_irq

//--- sim/dio_far_side_model.sv
// Far-side model: peripheral data lines, request strobes, final-count and timer outputs.
module dio_far_side_model (
    // Clock.
    input  wire logic        clk,
    // Pins toward the block.
    output logic [15:0]      group1_lines,
    output logic [15:0]      group2_lines,
    output logic             group1_request,
    output logic             group2_request,
    output logic             group1_dma_final_count,
    output logic             group2_dma_final_count,
    output logic             timer3_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] ev;

    assign group1_dma_final_count = ev[0];
    assign group2_dma_final_count = ev[1];
    assign timer3_out             = ev[2];

    initial begin
        group1_lines   = 16'h0000;
        group2_lines   = 16'h0000;
        group1_request = 1'b0;
        group2_request = 1'b0;
        ev             = 3'h0;
    end

    task automatic set_lines(input int g, input logic [15:0] v);
        @(posedge clk);
        if (g == 1) group1_lines <= v;
        else group2_lines <= v;
    endtask : set_lines

    // The level is held four clocks so it survives the input filter.
    task automatic set_req(input int g, input logic v);
        @(posedge clk);
        if (g == 1) group1_request <= v;
        else group2_request <= v;
        repeat (4) @(posedge clk);
    endtask : set_req

    task automatic pulse_event(input int k);
        @(posedge clk);
        ev <= 3'h1 << k;
        repeat (4) @(posedge clk);
        ev <= 3'h0;
        repeat (4) @(posedge clk);
    endtask : pulse_event
endmodule : dio_far_side_model

//--- sim/dio_input_latch_and_irq_tb.sv
// Self-checking bench for the input latch and interrupt block.
`include "dio_latch_irq_params.svh"

module dio_input_latch_and_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] group1_lines, group2_lines;
    logic group1_request, group2_request, group1_dma_final_count, group2_dma_final_count;
    logic timer3_out, group1_irq, group2_irq, irq;
    int fails = 0, check_count = 0;
    logic [31:0] rd;
    logic [1:0] rsp;

    initial begin
        forever #12.5 clk = ~clk;
    end

    dio_latch_irq i_dio_latch_irq (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .group1_lines(group1_lines), .group2_lines(group2_lines),
        .group1_request(group1_request), .group2_request(group2_request),
        .group1_dma_final_count(group1_dma_final_count),
        .group2_dma_final_count(group2_dma_final_count), .timer3_out(timer3_out),
        .group1_irq(group1_irq), .group2_irq(group2_irq), .irq(irq));

    dio_far_side_model i_dio_far_side_model (.clk(clk), .group1_lines(group1_lines),
        .group2_lines(group2_lines), .group1_request(group1_request),
        .group2_request(group2_request), .group1_dma_final_count(group1_dma_final_count),
        .group2_dma_final_count(group2_dma_final_count), .timer3_out(timer3_out));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Leave the answering edge so later samples see settled outputs.
        #1;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        #1;
    endtask : rdr

    // Reads a register and compares the word and an OKAY response.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rdr(a, rd, rsp);
        check(rd, exp);
        check({30'h0, rsp}, {30'h0, `RESP_OKAY});
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_map;
        rd_chk(`OFS_G1_SETUP, 32'h0);
        rd_chk(`OFS_SHARED, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0);
        rdr(8'h30, rd, rsp);
        check(rd, 32'h0);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        wr(8'h30, 32'h1, rsp);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    endtask : t_reset_and_map

    task automatic t_live_lines;
        wr(`OFS_G1_SETUP, 32'h60, rsp);
        i_dio_far_side_model.set_lines(1, 16'h1234);
        wt(8);
        rd_chk(`OFS_G1_PORT, 32'h1234);
        i_dio_far_side_model.set_lines(1, 16'h5678);
        wt(8);
        rd_chk(`OFS_G1_PORT, 32'h5678);
    endtask : t_live_lines

    task automatic t_level_mode;
        wr(`OFS_G1_SETUP, 32'h71, rsp);
        i_dio_far_side_model.set_lines(1, 16'haaaa);
        i_dio_far_side_model.set_req(1, 1'b1);
        i_dio_far_side_model.set_lines(1, 16'hbbbb);
        wt(8);
        check({31'h0, group1_irq}, 32'h1);
        rd_chk(`OFS_STATUS, 32'h01);
        rd_chk(`OFS_G1_PORT, 32'haaaa);
        wt(3);
        rd_chk(`OFS_STATUS, 32'h00);
        check({31'h0, group1_irq}, 32'h0);
        i_dio_far_side_model.set_req(1, 1'b0);
        wt(8);
        rd_chk(`OFS_G1_PORT, 32'hbbbb);
    endtask : t_level_mode

    task automatic t_leading_inverted;
        i_dio_far_side_model.set_req(2, 1'b1);
        wr(`OFS_G2_SETUP, 32'h7b, rsp);
        i_dio_far_side_model.set_lines(2, 16'hc0c0);
        wt(8);
        i_dio_far_side_model.set_req(2, 1'b0);
        i_dio_far_side_model.set_req(2, 1'b1);
        i_dio_far_side_model.set_lines(2, 16'hd0d0);
        i_dio_far_side_model.set_req(2, 1'b0);
        i_dio_far_side_model.set_req(2, 1'b1);
        wt(8);
        check({31'h0, group2_irq}, 32'h1);
        rd_chk(`OFS_STATUS, 32'h02);
        rd_chk(`OFS_G2_PORT, 32'hc0c0);
        rd_chk(`OFS_STATUS, 32'h00);
    endtask : t_leading_inverted

    task automatic t_trailing;
        wr(`OFS_G1_SETUP, 32'h77, rsp);
        i_dio_far_side_model.set_lines(1, 16'he1e1);
        i_dio_far_side_model.set_req(1, 1'b1);
        i_dio_far_side_model.set_lines(1, 16'hf1f1);
        wt(4);
        i_dio_far_side_model.set_req(1, 1'b0);
        wt(8);
        i_dio_far_side_model.set_lines(1, 16'h0707);
        rd_chk(`OFS_STATUS, 32'h01);
        wr(`OFS_G1_PORT, 32'h0, rsp);
        rd_chk(`OFS_STATUS, 32'h00);
        rd_chk(`OFS_G1_PORT, 32'hf1f1);
    endtask : t_trailing

    task automatic t_irq_sources;
        wr(`OFS_SHARED, 32'h7, rsp);
        wr(`OFS_MASK, 32'h0, rsp);
        for (int k = 0; k < 3; k++) i_dio_far_side_model.pulse_event(k);
        wt(4);
        rd_chk(`OFS_STATUS, 32'h1c);
        check({29'h0, group1_irq, group2_irq, irq}, 32'h6);
        wr(`OFS_MASK, 32'h1f, rsp);
        wt(3);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_G1_TC_ACK, 32'h0, rsp);
        wt(3);
        rd_chk(`OFS_STATUS, 32'h18);
        check({31'h0, group1_irq}, 32'h0);
        wr(`OFS_T3_ACK, 32'hffffffff, rsp);
        wt(3);
        rd_chk(`OFS_STATUS, 32'h08);
        check({31'h0, group2_irq}, 32'h1);
        wr(`OFS_G2_TC_ACK, 32'h0, rsp);
        wt(3);
        check({29'h0, group1_irq, group2_irq, irq}, 32'h0);
        wr(`OFS_SHARED, 32'h4, rsp);
        rd_chk(`OFS_SHARED, 32'h4);
        i_dio_far_side_model.pulse_event(0);
        wt(4);
        check({31'h0, group1_irq}, 32'h0);
        i_dio_far_side_model.pulse_event(2);
        wt(4);
        rd_chk(`OFS_STATUS, 32'h14);
        check({30'h0, group1_irq, group2_irq}, 32'h1);
        wr(`OFS_STATUS, 32'h1f, rsp);
        wt(3);
        rd_chk(`OFS_STATUS, 32'h00);
    endtask : t_irq_sources

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_and_map();
        t_live_lines();
        t_level_mode();
        t_leading_inverted();
        t_trailing();
        t_irq_sources();
        results();
    end
endmodule : dio_input_latch_and_irq_tb
